// ===== fault_mgr_defs.svh
// constants for the motor driver fault manager
// assumes inclusion by bare name before the package or module header
`ifndef FAULT_MGR_DEFS_SVH
`define FAULT_MGR_DEFS_SVH

// core clock period in picoseconds (125 MHz)
`define CLK_PERIOD_PS 8000
// overcurrent retry time in microseconds
`define OC_RETRY_US 500
// stall retry time in milliseconds
`define STALL_RETRY_MS 100
// stall detection time in milliseconds
`define STALL_DET_MS 1000
// derived cycle counts: cycles per unit first, so no product leaves 32 bits
`define OC_RETRY_CYC (`OC_RETRY_US * (1000000 / `CLK_PERIOD_PS))
`define STALL_RETRY_CYC (`STALL_RETRY_MS * (1000000000 / `CLK_PERIOD_PS))
`define STALL_DET_CYC (`STALL_DET_MS * (1000000000 / `CLK_PERIOD_PS))
// timer width
`define TIMER_W 32
// mode encodings
`define ACT_LATCH 2'b00
`define ACT_RETRY 2'b01
`define ACT_REPORT 2'b10
`define ACT_NONE 2'b11
// flag vector positions
`define FLG_FAULT 0
`define FLG_POR 1
`define FLG_BUCK 2
`define FLG_PUMP 3
`define FLG_OV 4
`define FLG_OC 5
`define FLG_SER 6
`define FLG_TRIM 7
`define FLG_STALL 8
`define FLG_WARN 9
`define FLG_OTS 10
`define FLG_W 11

`endif

// ===== fault_mgr_pkg.sv
// types shared by the fault manager modules
// assumes fault_mgr_defs.svh is available for inclusion
`include "fault_mgr_defs.svh"
package fault_mgr_pkg;
	// detector inputs grouped together
	typedef struct packed {
		logic supply_uv;
		logic analog_uv;
		logic flag_a;
		logic pump_undervoltage;
		logic overvoltage;
		logic overcurrent;
		logic serial_err;
		logic trim_err;
		logic hall_edge;
		logic thermal_warn;
		logic die_overtemp;
		logic fet_area_overtemp;
	} detect_type;
	// configuration inputs
	typedef struct packed {
		logic overvoltage_enable;
		logic [1:0] overcurrent_action_sel;
		logic serial_error_report_off;
		logic [1:0] stall_action_sel;
		logic thermal_warn_report_en;
	} config_type;
	// retry state machine, one-hot
	typedef enum logic [2:0] {
		RT_IDLE = 3'b001,
		RT_WAIT = 3'b010,
		RT_HOLD = 3'b100
	} retry_state_type;
endpackage : fault_mgr_pkg

// ===== retry_timer.sv
// retry timer: holds the FETs off for a set count after a trigger
// assumes synchronous trigger and a level-sensitive mode enable
`timescale 1ns/1ps
`default_nettype none
`include "fault_mgr_defs.svh"
module retry_timer
	import fault_mgr_pkg::*;
#(
	parameter logic [`TIMER_W-1:0] RETRY_CYC = 32'h0000_0010
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic trigger,
	input wire logic clr,
	output logic busy,
	output logic done
);
	// ==================================================
	// state
	typedef struct packed {
		retry_state_type st;
		logic [`TIMER_W-1:0] cnt;
		logic done;
	} st_type;
	st_type s_r, s_nxt;

	// next state: count down then release with a done pulse
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			RT_IDLE: begin
				if (trigger) begin
					s_nxt.st = RT_WAIT;
					s_nxt.cnt = RETRY_CYC;
				end
			end
			RT_WAIT: begin
				// clear command ends the wait early
				if (clr) begin
					s_nxt.st = RT_IDLE;
				end else if (s_r.cnt <= 32'h0000_0001) begin
					s_nxt.st = RT_HOLD;
					s_nxt.done = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt - 32'h0000_0001;
				end
			end
			RT_HOLD: begin
				s_nxt.st = RT_IDLE;
			end
			default: begin
				s_nxt.st = RT_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{st: RT_IDLE, cnt: '0, done: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign busy = (s_r.st == RT_WAIT);
	assign done = s_r.done;
endmodule : retry_timer
`default_nettype wire

// ===== stall_timer.sv
// stall detector: counts cycles since the last hall transition
// assumes hall_edge is a one-cycle pulse per valid transition
`timescale 1ns/1ps
`default_nettype none
`include "fault_mgr_defs.svh"
module stall_timer
	import fault_mgr_pkg::*;
#(
	parameter logic [`TIMER_W-1:0] DET_CYC = 32'h0000_0100
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hall_edge,
	input wire logic run,
	output logic stalled
);
	// ==================================================
	// state
	typedef struct packed {
		logic [`TIMER_W-1:0] cnt;
		logic stalled;
	} st_type;
	st_type s_r, s_nxt;

	// count idle cycles, restart on any edge or when not running
	always_comb begin
		s_nxt = s_r;
		if (hall_edge || !run) begin
			s_nxt.cnt = '0;
			s_nxt.stalled = 1'b0;
		end else if (s_r.cnt >= DET_CYC - 32'h0000_0001) begin
			s_nxt.stalled = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 32'h0000_0001;
		end
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{cnt: '0, stalled: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign stalled = s_r.stalled;
endmodule : stall_timer
`default_nettype wire

// ===== motor_driver_fault_manager.sv
// fault supervision for a three-phase motor driver
// assumes synchronous detector inputs and power-on reset on rst_n
`timescale 1ns/1ps
`default_nettype none
`include "fault_mgr_defs.svh"
module motor_driver_fault_manager
	import fault_mgr_pkg::*;
#(
	parameter logic [`TIMER_W-1:0] OC_RETRY_CYC = `OC_RETRY_CYC,
	parameter logic [`TIMER_W-1:0] STALL_RETRY_CYC = `STALL_RETRY_CYC,
	parameter logic [`TIMER_W-1:0] STALL_DET_CYC = `STALL_DET_CYC
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire detect_type det,
	input wire config_type cfg,
	input wire logic clear_faults_cmd,
	input wire logic sleep_reset_pulse,
	input wire logic motor_run,
	output logic fets_hiz,
	output logic pump_enable,
	output logic logic_enable,
	output logic fault_n_pin,
	output logic [`FLG_W-1:0] chip_status_reg,
	output logic buck_fault_flag
);
	// ==================================================
	// state
	typedef struct packed {
		logic [`FLG_W-1:0] flags;
		logic oc_latched;
		logic stall_latched;
		logic stall_report;
		logic uv_seen;
		logic fets_hiz;
		logic pump_en;
		logic logic_en;
		logic fault_n;
	} st_type;
	st_type s_r, s_nxt;

	// ==================================================
	// timers
	logic oc_busy, oc_done, st_busy, stalled;
	logic oc_trig, st_trig, clr_any;

	assign clr_any = clear_faults_cmd || sleep_reset_pulse;
	assign oc_trig = det.overcurrent && !oc_busy
		&& (cfg.overcurrent_action_sel == `ACT_RETRY);
	assign st_trig = stalled && !st_busy
		&& (cfg.stall_action_sel == `ACT_RETRY);

	// overcurrent retry timer
	retry_timer #(.RETRY_CYC(OC_RETRY_CYC)) u_oc_retry (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.trigger(oc_trig),
		.clr(clr_any),
		.busy(oc_busy),
		.done(oc_done)
	);

	// stall retry timer
	retry_timer #(.RETRY_CYC(STALL_RETRY_CYC)) u_st_retry (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.trigger(st_trig),
		.clr(clr_any),
		.busy(st_busy),
		.done()
	);

	// hall activity watchdog, held at zero count while FETs are off
	stall_timer #(.DET_CYC(STALL_DET_CYC)) u_stall (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.hall_edge(det.hall_edge),
		.run(motor_run && !s_r.fets_hiz),
		.stalled(stalled)
	);

	// ==================================================
	// next state
	logic uv_now, ov_now, ots_now, oc_act, st_act;
	logic [`FLG_W-1:0] set_v, cause_v;
	logic hiz, report;

	always_comb begin
		s_nxt = s_r;
		uv_now = det.supply_uv || det.analog_uv;
		ov_now = det.overvoltage && cfg.overvoltage_enable;
		ots_now = det.die_overtemp || det.fet_area_overtemp;
		oc_act = det.overcurrent
			&& (cfg.overcurrent_action_sel == `ACT_LATCH
			|| cfg.overcurrent_action_sel == `ACT_RETRY);
		st_act = stalled && (cfg.stall_action_sel != `ACT_NONE);
		// flags set this cycle
		set_v = '0;
		set_v[`FLG_BUCK] = det.flag_a;
		set_v[`FLG_PUMP] = det.pump_undervoltage;
		set_v[`FLG_OV] = ov_now;
		set_v[`FLG_OC] = oc_act;
		set_v[`FLG_SER] = det.serial_err && !cfg.serial_error_report_off;
		set_v[`FLG_TRIM] = det.trim_err;
		set_v[`FLG_STALL] = st_act;
		set_v[`FLG_WARN] = det.thermal_warn;
		set_v[`FLG_OTS] = ots_now;
		// por flag set (latched high in status) on recovery from undervoltage
		set_v[`FLG_POR] = s_r.uv_seen && !uv_now;
		set_v[`FLG_FAULT] = |set_v[`FLG_OTS:`FLG_BUCK];
		// conditions still present block a clear
		cause_v = set_v;
		cause_v[`FLG_POR] = uv_now;
		cause_v[`FLG_TRIM] = 1'b1; // only sleep reset clears trim error
		cause_v[`FLG_FAULT] = 1'b0;
		s_nxt.uv_seen = uv_now || (s_r.uv_seen && uv_now);
		// clear first, set wins
		if (clear_faults_cmd) begin
			s_nxt.flags = s_r.flags & cause_v;
		end
		if (sleep_reset_pulse) begin
			s_nxt.flags = s_r.flags & (cause_v & ~(`FLG_W'(1) << `FLG_TRIM));
		end
		s_nxt.flags = s_nxt.flags | set_v;
		if (s_nxt.flags[`FLG_OTS:`FLG_BUCK] != '0) begin
			s_nxt.flags[`FLG_FAULT] = 1'b1;
		end
		// overcurrent latched shutdown until clear
		if (det.overcurrent && cfg.overcurrent_action_sel == `ACT_LATCH) begin
			s_nxt.oc_latched = 1'b1;
		end else if (clr_any && !det.overcurrent) begin
			s_nxt.oc_latched = 1'b0;
		end
		// stall latch or report until clear
		if (stalled && cfg.stall_action_sel == `ACT_LATCH) begin
			s_nxt.stall_latched = 1'b1;
		end else if (clr_any && !stalled) begin
			s_nxt.stall_latched = 1'b0;
		end
		if (stalled && cfg.stall_action_sel == `ACT_REPORT) begin
			s_nxt.stall_report = 1'b1;
		end else if (clr_any && !stalled) begin
			s_nxt.stall_report = 1'b0;
		end
		// FET tri-state decision
		hiz = uv_now || ov_now || ots_now || det.pump_undervoltage
			|| s_nxt.flags[`FLG_TRIM] || s_nxt.oc_latched
			|| oc_busy || oc_trig || s_nxt.stall_latched
			|| st_busy || st_trig;
		// fault pin reporting
		report = det.flag_a || det.pump_undervoltage || ov_now
			|| s_nxt.oc_latched || oc_busy || oc_trig
			|| (det.serial_err && !cfg.serial_error_report_off)
			|| s_nxt.flags[`FLG_SER]
			|| s_nxt.flags[`FLG_TRIM] || s_nxt.stall_latched
			|| st_busy || st_trig || s_nxt.stall_report
			|| (det.thermal_warn && cfg.thermal_warn_report_en)
			|| ots_now;
		s_nxt.fets_hiz = hiz;
		s_nxt.pump_en = !uv_now;
		s_nxt.logic_en = !uv_now;
		s_nxt.fault_n = !(report && !uv_now);
	end

	// state register
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{flags: '0, oc_latched: 1'b0, stall_latched: 1'b0,
				stall_report: 1'b0, uv_seen: 1'b0, fets_hiz: 1'b1,
				pump_en: 1'b0, logic_en: 1'b0, fault_n: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ==================================================
	// outputs straight from flops
	assign fets_hiz = s_r.fets_hiz;
	assign pump_enable = s_r.pump_en;
	assign logic_enable = s_r.logic_en;
	assign fault_n_pin = s_r.fault_n;
	assign chip_status_reg = s_r.flags;
	assign buck_fault_flag = s_r.flags[`FLG_BUCK];

	// ==================================================
	// checks
	// supply undervoltage shuts FETs, pump and logic
	chk_uv_hiz: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		det.supply_uv |=> fets_hiz && !pump_enable && !logic_enable)
		else $error("undervoltage did not shut down");

	// analog rail undervoltage shuts FETs and logic
	chk_avdd_hiz: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		det.analog_uv |=> fets_hiz && !logic_enable)
		else $error("analog undervoltage did not shut down");

	// rails back: pump and logic return without a command
	chk_uv_resume: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		!uv_now |=> pump_enable && logic_enable)
		else $error("no automatic restart after undervoltage");

	// por flag latched on the cycle the rails return
	chk_por_latch: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		!uv_now && $past(uv_now) && $past(rst_n)
		|=> chip_status_reg[`FLG_POR])
		else $error("por flag not latched");

	// buck undervoltage reported, drive left running
	chk_buck_pin: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		det.flag_a && !det.supply_uv && !det.analog_uv
		|=> !fault_n_pin && buck_fault_flag)
		else $error("buck undervoltage not reported");

	// buck flag only falls after a clear or sleep pulse
	chk_buck_hold: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		buck_fault_flag && !clear_faults_cmd && !sleep_reset_pulse
		|=> buck_fault_flag)
		else $error("buck flag dropped without clear");

	// clear pulse drops a flag whose cause is gone
	chk_clear_flags: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		clear_faults_cmd && !det.flag_a |=> !buck_fault_flag)
		else $error("clear left a stale flag");

	// disabled overvoltage never raises its flag
	chk_ov_off: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		det.overvoltage && !cfg.overvoltage_enable |=>
		!chip_status_reg[`FLG_OV] || $past(chip_status_reg[`FLG_OV]))
		else $error("disabled overvoltage set flag");

	// latched overcurrent: FETs off, pin low, flag up
	chk_oc_latch: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		det.overcurrent && cfg.overcurrent_action_sel == `ACT_LATCH
		&& !uv_now |=> fets_hiz && !fault_n_pin && chip_status_reg[`FLG_OC])
		else $error("latched overcurrent not acted on");

	// retry overcurrent: FETs off and pin low during the wait
	chk_oc_retry: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		det.overcurrent && cfg.overcurrent_action_sel == `ACT_RETRY
		&& !uv_now |=> fets_hiz && !fault_n_pin)
		else $error("retry overcurrent not acted on");

	// overcurrent flag survives the automatic restart
	chk_oc_sticky: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		oc_done |=> chip_status_reg[`FLG_OC] || $past(clr_any))
		else $error("overcurrent flag lost at retry");

	// serial error reported while reporting is on
	chk_ser_report: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		det.serial_err && !cfg.serial_error_report_off && !uv_now
		|=> !fault_n_pin && chip_status_reg[`FLG_SER])
		else $error("serial error not reported");

	// serial error ignored while reporting is off
	chk_ser_quiet: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		det.serial_err && cfg.serial_error_report_off
		&& !chip_status_reg[`FLG_SER] |=> !chip_status_reg[`FLG_SER])
		else $error("suppressed serial error set flag");

	// trim error holds FETs off until a sleep pulse
	chk_trim_latch: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		chip_status_reg[`FLG_TRIM] && !sleep_reset_pulse
		|=> chip_status_reg[`FLG_TRIM] && fets_hiz)
		else $error("trim error released early");

	// latched stall: FETs off and flag up
	chk_stall_latch: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		stalled && cfg.stall_action_sel == `ACT_LATCH
		|=> fets_hiz && chip_status_reg[`FLG_STALL])
		else $error("latched stall not acted on");

	// stall with no action leaves the flag alone
	chk_stall_quiet: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		stalled && cfg.stall_action_sel == `ACT_NONE
		&& !chip_status_reg[`FLG_STALL] |=> !chip_status_reg[`FLG_STALL])
		else $error("ignored stall set flag");

	// reported thermal warning pulls the pin low
	chk_warn_pin: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		det.thermal_warn && cfg.thermal_warn_report_en && !uv_now
		|=> !fault_n_pin && chip_status_reg[`FLG_WARN])
		else $error("thermal warning not reported");

	// thermal shutdown: FETs off and flag up
	chk_tsd_hiz: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		det.die_overtemp |=> fets_hiz && chip_status_reg[`FLG_OTS])
		else $error("thermal shutdown not acted on");

	// pump undervoltage: FETs off and flag up
	chk_pump_hiz: assert property (
		@(posedge core_clk) disable iff (!rst_n)
		det.pump_undervoltage |=> fets_hiz && chip_status_reg[`FLG_PUMP])
		else $error("pump undervoltage not acted on");
endmodule : motor_driver_fault_manager
`default_nettype wire

// ===== host_model.sv
// host controller model: turns bench requests into one-cycle pulses
// assumes requests are raised for exactly one core_clk edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clear_req,
	input wire logic sleep_req,
	output logic clear_faults_cmd,
	output logic sleep_reset_pulse
);
	// ==========================================
	// pulse launch
	// registered so pulses change just after an edge
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clear_faults_cmd <= 1'h0;
			sleep_reset_pulse <= 1'h0;
		end else begin
			clear_faults_cmd <= clear_req;
			sleep_reset_pulse <= sleep_req;
		end
	end
endmodule : host_model
`default_nettype wire

// ===== tb_motor_driver_fault_manager.sv
// self-checking bench for the fault manager
// assumes short timer parameters of 16 cycles and a 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "fault_mgr_defs.svh"
module tb_motor_driver_fault_manager
	import fault_mgr_pkg::*;
;
	// ==========================================
	// signals
	logic core_clk, rst_n, motor_run, clr_req, slp_req; // bench drives
	logic fets_hiz, pump_enable, logic_enable, fault_n_pin, buck_fault_flag;
	logic clear_faults_cmd, sleep_reset_pulse; // from host model
	logic [`FLG_W-1:0] flags; // status flags
	detect_type det; // detector levels
	detect_type d; // scratch value
	config_type cfg; // configuration
	int err_count, checks, cyc;
	int fi; // flag position under test
	logic e_fl; // overcurrent select expected to act
	// ==========================================
	// instances
	motor_driver_fault_manager #(.OC_RETRY_CYC(32'h0000_0010),
		.STALL_RETRY_CYC(32'h0000_0010), .STALL_DET_CYC(32'h0000_0010)) dut (
		.core_clk(core_clk), .rst_n(rst_n), .det(det), .cfg(cfg),
		.clear_faults_cmd(clear_faults_cmd), .sleep_reset_pulse(sleep_reset_pulse),
		.motor_run(motor_run), .fets_hiz(fets_hiz), .pump_enable(pump_enable),
		.logic_enable(logic_enable), .fault_n_pin(fault_n_pin),
		.chip_status_reg(flags), .buck_fault_flag(buck_fault_flag));
	host_model host (.core_clk(core_clk), .rst_n(rst_n), .clear_req(clr_req),
		.sleep_req(slp_req), .clear_faults_cmd(clear_faults_cmd),
		.sleep_reset_pulse(sleep_reset_pulse));
	// ==========================================
	// clock and hang guard
	initial begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			conclude();
		end
	end
	// ==========================================
	// tasks
	task automatic conclude();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	// wait n edges, then step past them
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task automatic cmp(input string name, input logic [10:0] e,
		input logic [10:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask : cmp
	// apply detector levels and let them settle
	task automatic drive(input detect_type v);
		@(posedge core_clk);
		det <= v;
		tick(3);
	endtask : drive
	// clear pulse, or sleep-reset pulse when slp is set
	task automatic pulse(input logic slp);
		@(posedge core_clk);
		if (slp) slp_req <= 1'h1;
		else clr_req <= 1'h1;
		@(posedge core_clk);
		clr_req <= 1'h0;
		slp_req <= 1'h0;
		tick(3);
	endtask : pulse
	// pins, plus one flag when idx is not negative
	task automatic look(input logic hz, input logic fn, input int idx,
		input logic fl);
		cmp("fets_hiz", {10'h000, hz}, {10'h000, fets_hiz});
		cmp("fault_n_pin", {10'h000, fn}, {10'h000, fault_n_pin});
		if (idx >= 0) cmp("flag", {10'h000, fl}, {10'h000, flags[idx]});
	endtask : look
	// ==========================================
	// main sequence
	initial begin
		rst_n = 1'h0;
		det = '0;
		cfg = '0;
		cfg.stall_action_sel = 2'h3;
		cfg.overvoltage_enable = 1'h1;
		cfg.thermal_warn_report_en = 1'h1;
		motor_run = 1'h0;
		clr_req = 1'h0;
		slp_req = 1'h0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'h1;
		tick(2);
		// supply and analog rail undervoltage
		for (int i = 0; i < 2; i++) begin
			d = '0;
			if (i == 0) d.supply_uv = 1'h1;
			else d.analog_uv = 1'h1;
			drive(d);
			look(1'h1, 1'h1, -1, 1'h0);
			cmp("pump_logic", 11'h000, {9'h000, pump_enable, logic_enable});
			drive('0);
			look(1'h0, 1'h1, `FLG_POR, 1'h1);
			cmp("logic_enable", 11'h001, {10'h000, logic_enable});
			pulse(1'h0);
			look(1'h0, 1'h1, `FLG_POR, 1'h0);
		end
		// protecting faults with automatic recovery
		for (int k = 0; k < 4; k++) begin
			d = '0;
			case (k)
				0: d.pump_undervoltage = 1'h1;
				1: d.overvoltage = 1'h1;
				2: d.die_overtemp = 1'h1;
				default: d.fet_area_overtemp = 1'h1;
			endcase
			fi = k == 0 ? `FLG_PUMP : k == 1 ? `FLG_OV : `FLG_OTS;
			drive(d);
			look(1'h1, 1'h0, fi, 1'h1);
			drive('0);
			look(1'h0, 1'h1, fi, 1'h1);
			pulse(1'h0);
			look(1'h0, 1'h1, fi, 1'h0);
		end
		cfg.overvoltage_enable <= 1'h0;
		d = '0;
		d.overvoltage = 1'h1;
		drive(d);
		look(1'h0, 1'h1, `FLG_OV, 1'h0);
		drive('0);
		// report-only faults: buck undervoltage and thermal warning
		for (int k = 0; k < 2; k++) begin
			d = '0;
			if (k == 0) d.flag_a = 1'h1;
			else d.thermal_warn = 1'h1;
			fi = k == 0 ? `FLG_BUCK : `FLG_WARN;
			drive(d);
			look(1'h0, 1'h0, fi, 1'h1);
			cmp("fault_flag", 11'h001, {10'h000, flags[`FLG_FAULT]});
			pulse(1'h0);
			look(1'h0, 1'h0, fi, 1'h1);
			cmp("pump_enable", 11'h001, {10'h000, pump_enable});
			drive('0);
			look(1'h0, 1'h1, fi, 1'h1);
			if (k == 0) cmp("buck_fault_flag", 11'h001, {10'h000, buck_fault_flag});
			pulse(1'h0);
			look(1'h0, 1'h1, fi, 1'h0);
			cmp("fault_flag", 11'h000, {10'h000, flags[`FLG_FAULT]});
		end
		cfg.thermal_warn_report_en <= 1'h0;
		d = '0;
		d.thermal_warn = 1'h1;
		drive(d);
		look(1'h0, 1'h1, `FLG_WARN, 1'h1);
		drive('0);
		pulse(1'h1);
		// serial error, reported then suppressed
		for (int k = 0; k < 2; k++) begin
			cfg.serial_error_report_off <= k[0];
			d = '0;
			d.serial_err = 1'h1;
			drive(d);
			look(1'h0, k == 0 ? 1'h0 : 1'h1, `FLG_SER, k == 0 ? 1'h1 : 1'h0);
			drive('0);
			pulse(1'h0);
			look(1'h0, 1'h1, `FLG_SER, 1'h0);
		end
		// overcurrent latched, timed retry, then an ignored select
		for (int k = 0; k < 3; k++) begin
			cfg.overcurrent_action_sel <= k[1:0];
			e_fl = (k < 2);
			d = '0;
			d.overcurrent = 1'h1;
			drive(d);
			look(e_fl, !e_fl, `FLG_OC, e_fl);
			drive('0);
			look(e_fl, !e_fl, `FLG_OC, e_fl);
			tick(20);
			look(k == 0, k != 0, `FLG_OC, e_fl);
			pulse(1'h0);
			look(1'h0, 1'h1, `FLG_OC, 1'h0);
		end
		// trim error ignores clear, yields to sleep reset
		d = '0;
		d.trim_err = 1'h1;
		drive(d);
		drive('0);
		pulse(1'h0);
		look(1'h1, 1'h0, `FLG_TRIM, 1'h1);
		pulse(1'h1);
		look(1'h0, 1'h1, `FLG_TRIM, 1'h0);
		// stall: hall edges keep it quiet, then each action mode
		for (int k = 0; k < 4; k++) begin
			cfg.stall_action_sel <= k[1:0];
			motor_run <= 1'h1;
			if (k == 0) begin
				repeat (6) begin
					tick(7);
					det.hall_edge <= 1'h1;
					tick(1);
					det.hall_edge <= 1'h0;
				end
				look(1'h0, 1'h1, `FLG_STALL, 1'h0);
			end
			tick(24);
			look(k < 2, k == 3, `FLG_STALL, k != 3);
			motor_run <= 1'h0;
			tick(20);
			look(k == 0, k[0], `FLG_STALL, k != 3);
			pulse(1'h0);
			look(1'h0, 1'h1, `FLG_STALL, 1'h0);
		end
		conclude();
	end
endmodule : tb_motor_driver_fault_manager
`default_nettype wire
